// ===== core/ctrl_link_if.sv
// Purpose: Wires of the serial control link between host and device.
// Assumes: The shared data line is pulled high when nobody drives it.
// Notes:   Resolves the two-way data line from both output enables.
interface ctrl_link_if;

  // ---------------------------------------------------------------
  // Link signals
  // ---------------------------------------------------------------
  logic sclk;
  logic cs_n;
  logic sdio_host_out;
  logic sdio_host_oe;
  logic sdio_dev_out;
  logic sdio_dev_oe;
  logic serial_data_output_line;
  logic serial_data_output_oe;
  logic sdio;

  // The host wins if both drive; a pull-up holds the idle level.
  assign sdio = sdio_host_oe ? sdio_host_out : (sdio_dev_oe ? sdio_dev_out : 1'b1);

  modport host
  (
    output sclk,
    output cs_n,
    output sdio_host_out,
    output sdio_host_oe,
    input sdio,
    input serial_data_output_line,
    input serial_data_output_oe
  );

  modport device
  (
    input sclk,
    input cs_n,
    input sdio,
    output sdio_dev_out,
    output sdio_dev_oe,
    output serial_data_output_line,
    output serial_data_output_oe
  );

endinterface : ctrl_link_if

// ===== core/ctrl_port_device.sv
// Purpose: Device end of the serial control port with its byte registers.
// Assumes: Host makes the link clock and only toggles it inside frames.
// Notes:   Register file lives on the link clock; writes are echoed to ref_clk.
module ctrl_port_device
  import ctrl_port_pkg::*;
(
  // Reference clock domain
  input wire logic ref_clk,
  input wire logic rst,
  // Configuration
  input wire logic three_wire,
  // Echo of committed register writes
  output logic cfg_wr_pulse,
  output logic [ADDR_BITS-1:0] cfg_wr_addr,
  output logic [DATA_BITS-1:0] cfg_wr_data,
  // Serial link
  ctrl_link_if.device link
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic link_rst;
  logic next_link_rst;
  logic frame_rst;
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic [ADDR_BITS-1:0] shift_in;
  logic [ADDR_BITS-1:0] next_shift_in;
  logic is_read;
  logic next_is_read;
  logic [ADDR_BITS-1:0] frame_addr;
  logic [ADDR_BITS-1:0] next_frame_addr;
  logic [DATA_BITS-1:0] regs [REG_COUNT];
  logic [DATA_BITS-1:0] wr_byte;
  logic wr_now;
  logic addr_hit;
  logic [ADDR_BITS-1:0] hold_addr;
  logic [DATA_BITS-1:0] hold_data;
  logic wr_tog;
  logic mode_meta;
  logic mode_sync;
  logic [DATA_BITS-1:0] rd_byte;
  logic [DATA_BITS-1:0] rd_shift;
  logic [DATA_BITS-1:0] next_rd_shift;
  logic next_dev_out;
  logic next_dev_oe;
  logic next_line;
  logic next_line_oe;
  logic tog_meta;
  logic tog_sync;
  logic tog_seen;
  logic next_pulse;
  logic [ADDR_BITS-1:0] next_wr_addr;
  logic [DATA_BITS-1:0] next_wr_data;

  // ---------------------------------------------------------------
  // Reset into the link domain
  // ---------------------------------------------------------------

  // A registered copy of rst gives a glitch-free clear for the link side.
  assign next_link_rst = rst;

  always_ff @(posedge ref_clk)
  begin
    link_rst <= next_link_rst;
  end

  // Chip select high ends any frame at once, even with the clock stopped.
  assign frame_rst = link_rst | link.cs_n;

  // ---------------------------------------------------------------
  // Wiring option synchroniser
  // ---------------------------------------------------------------

  // The option is static during frames but still crosses two stages.
  always_ff @(posedge link.sclk or posedge link_rst)
  begin
    if (link_rst)
    begin
      mode_meta <= 1'b0;
      mode_sync <= 1'b0;
    end
    else
    begin
      mode_meta <= three_wire;
      mode_sync <= mode_meta;
    end
  end

  // ---------------------------------------------------------------
  // Header capture on the rising edge
  // ---------------------------------------------------------------

  // Counts bits and latches direction and address after the header.
  always_comb
  begin
    next_cnt = cnt;
    next_shift_in = {shift_in[ADDR_BITS-2:0], link.sdio};
    next_is_read = is_read;
    next_frame_addr = frame_addr;
    if (cnt != FRAME_COUNT)
    begin
      next_cnt = cnt + 5'd1;
    end
    if (cnt == HEAD_LAST)
    begin
      next_is_read = (shift_in[ADDR_BITS-1] == DIR_READ);
      next_frame_addr = {shift_in[ADDR_BITS-2:0], link.sdio};
    end
  end

  always_ff @(posedge link.sclk or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      cnt <= 5'h00;
      shift_in <= '0;
      is_read <= 1'b0;
      frame_addr <= '0;
    end
    else
    begin
      cnt <= next_cnt;
      shift_in <= next_shift_in;
      is_read <= next_is_read;
      frame_addr <= next_frame_addr;
    end
  end

  // ---------------------------------------------------------------
  // Register file and write commit
  // ---------------------------------------------------------------

  // The 24th bit of a write frame completes the byte; bits after it in longer frames are ignored.
  assign wr_byte = {shift_in[DATA_BITS-2:0], link.sdio};
  assign wr_now = !frame_rst && (cnt == FRAME_LAST) && !is_read;
  assign addr_hit = (frame_addr < ADDR_BITS'(REG_COUNT));

  always_ff @(posedge link.sclk or posedge link_rst)
  begin
    if (link_rst)
    begin
      for (int i = 0; i < REG_COUNT; i++)
      begin
        regs[i] <= REG_RESET;
      end
      hold_addr <= '0;
      hold_data <= '0;
      wr_tog <= 1'b0;
    end
    else if (wr_now)
    begin
      if (addr_hit)
      begin
        regs[frame_addr[3:0]] <= wr_byte;
      end
      hold_addr <= frame_addr;
      hold_data <= wr_byte;
      wr_tog <= !wr_tog;
    end
  end

  // Unmapped addresses read back as zero.
  assign rd_byte = addr_hit ? regs[frame_addr[3:0]] : REG_RESET;

  // ---------------------------------------------------------------
  // Read data on the falling edge
  // ---------------------------------------------------------------

  // Drives bits 16 to 23 of a read frame, MSB first, on the chosen line.
  always_comb
  begin
    next_rd_shift = rd_shift;
    next_dev_out = link.sdio_dev_out;
    next_dev_oe = 1'b0;
    next_line = link.serial_data_output_line;
    next_line_oe = 1'b0;
    if (is_read && cnt == HEAD_COUNT)
    begin
      next_rd_shift = {rd_byte[DATA_BITS-2:0], 1'b0};
      next_dev_out = rd_byte[DATA_BITS-1];
      next_line = rd_byte[DATA_BITS-1];
      next_dev_oe = mode_sync;
      next_line_oe = !mode_sync;
    end
    else if (is_read && cnt > HEAD_COUNT && cnt < FRAME_COUNT)
    begin
      next_rd_shift = {rd_shift[DATA_BITS-2:0], 1'b0};
      next_dev_out = rd_shift[DATA_BITS-1];
      next_line = rd_shift[DATA_BITS-1];
      next_dev_oe = mode_sync;
      next_line_oe = !mode_sync;
    end
  end

  always_ff @(negedge link.sclk or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      rd_shift <= '0;
      link.sdio_dev_out <= 1'b0;
      link.sdio_dev_oe <= 1'b0;
      link.serial_data_output_line <= 1'b0;
      link.serial_data_output_oe <= 1'b0;
    end
    else
    begin
      rd_shift <= next_rd_shift;
      link.sdio_dev_out <= next_dev_out;
      link.sdio_dev_oe <= next_dev_oe;
      link.serial_data_output_line <= next_line;
      link.serial_data_output_oe <= next_line_oe;
    end
  end

  // ---------------------------------------------------------------
  // Write echo into the reference domain
  // ---------------------------------------------------------------

  // The toggle crosses in two stages; the held word is stable for a frame.
  always_comb
  begin
    next_pulse = tog_sync ^ tog_seen;
    next_wr_addr = cfg_wr_addr;
    next_wr_data = cfg_wr_data;
    if (tog_sync ^ tog_seen)
    begin
      next_wr_addr = hold_addr;
      next_wr_data = hold_data;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      tog_seen <= 1'b0;
      cfg_wr_pulse <= 1'b0;
      cfg_wr_addr <= '0;
      cfg_wr_data <= '0;
    end
    else
    begin
      tog_meta <= wr_tog;
      tog_sync <= tog_meta;
      tog_seen <= tog_sync;
      cfg_wr_pulse <= next_pulse;
      cfg_wr_addr <= next_wr_addr;
      cfg_wr_data <= next_wr_data;
    end
  end

endmodule : ctrl_port_device

// ===== core/ctrl_port_host.sv
// Purpose: Host end of the serial control port, frames one access at a time.
// Assumes: Link clock is ref_clk divided by eight.
// Notes:   Data changes on falling edges; read bits sampled late in the high phase.
module ctrl_port_host
  import ctrl_port_pkg::*;
(
  // Reference clock domain
  input wire logic ref_clk,
  input wire logic rst,
  // Configuration
  input wire logic three_wire,
  // Request
  input wire logic req_valid,
  input wire logic req_read,
  input wire logic [ADDR_BITS-1:0] req_addr,
  input wire logic [DATA_BITS-1:0] req_data,
  output logic req_ready,
  // Answer
  output logic resp_valid,
  output logic [DATA_BITS-1:0] resp_data,
  // Serial link
  ctrl_link_if.host link
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  host_state_t state;
  host_state_t next_state;
  logic [2:0] div;
  logic [2:0] next_div;
  logic [4:0] bit_idx;
  logic [4:0] next_bit_idx;
  logic [FRAME_BITS-1:0] shreg;
  logic [FRAME_BITS-1:0] next_shreg;
  logic [DATA_BITS-1:0] rx;
  logic [DATA_BITS-1:0] next_rx;
  logic is_read;
  logic next_is_read;
  logic next_sclk;
  logic next_cs_n;
  logic next_out;
  logic next_oe;
  logic next_ready;
  logic next_resp_valid;
  logic [DATA_BITS-1:0] next_resp_data;
  logic sdio_meta;
  logic sdio_sync;
  logic line_meta;
  logic line_sync;
  logic din;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------

  // Both data inputs cross two stages before the sampler reads them.
  always_ff @(posedge ref_clk)
  begin
    sdio_meta <= link.sdio;
    sdio_sync <= sdio_meta;
    line_meta <= link.serial_data_output_line;
    line_sync <= line_meta;
  end

  assign din = three_wire ? sdio_sync : line_sync;

  // ---------------------------------------------------------------
  // Frame sequencer
  // ---------------------------------------------------------------

  // Builds the 24-bit frame and the divided link clock.
  always_comb
  begin
    next_state = state;
    next_div = div + 3'd1;
    next_bit_idx = bit_idx;
    next_shreg = shreg;
    next_rx = rx;
    next_is_read = is_read;
    next_sclk = link.sclk;
    next_cs_n = link.cs_n;
    next_out = link.sdio_host_out;
    next_oe = link.sdio_host_oe;
    next_ready = req_ready;
    next_resp_valid = 1'b0;
    next_resp_data = resp_data;
    unique case (state)
      H_IDLE:
      begin
        next_div = 3'd0;
        next_ready = 1'b1;
        if (req_valid && req_ready)
        begin
          next_shreg = {(req_read ? DIR_READ : !DIR_READ), req_addr, req_data};
          next_is_read = req_read;
          next_cs_n = 1'b0;
          next_ready = 1'b0;
          next_state = H_LEAD;
        end
      end
      H_LEAD:
      begin
        if (div == DIV_CS_RISE)
        begin
          next_div = 3'd0;
          next_bit_idx = 5'd0;
          next_state = H_BITS;
        end
      end
      H_BITS:
      begin
        if (div == 3'd0)
        begin
          next_sclk = 1'b0;
          next_out = shreg[FRAME_BITS-1];
          next_oe = !(is_read && bit_idx >= HEAD_COUNT);
          next_shreg = {shreg[FRAME_BITS-2:0], 1'b0};
        end
        if (div == DIV_HALF)
        begin
          next_sclk = 1'b1;
        end
        if (div == DIV_LAST)
        begin
          next_rx = {rx[DATA_BITS-2:0], din};
          if (bit_idx == FRAME_LAST)
          begin
            next_state = H_TAIL;
          end
          else
          begin
            next_bit_idx = bit_idx + 5'd1;
          end
        end
      end
      H_TAIL:
      begin
        if (div == 3'd0)
        begin
          next_sclk = 1'b0;
          next_oe = 1'b0;
        end
        if (div == DIV_CS_RISE)
        begin
          next_cs_n = 1'b1;
          next_resp_valid = is_read;
          next_resp_data = rx;
        end
        if (div == DIV_LAST)
        begin
          next_ready = 1'b1;
          next_state = H_IDLE;
        end
      end
      default:
      begin
        next_state = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state <= H_IDLE;
      div <= 3'd0;
      bit_idx <= 5'd0;
      shreg <= '0;
      rx <= '0;
      is_read <= 1'b0;
      link.sclk <= 1'b0;
      link.cs_n <= 1'b1;
      link.sdio_host_out <= 1'b0;
      link.sdio_host_oe <= 1'b0;
      req_ready <= 1'b0;
      resp_valid <= 1'b0;
      resp_data <= '0;
    end
    else
    begin
      state <= next_state;
      div <= next_div;
      bit_idx <= next_bit_idx;
      shreg <= next_shreg;
      rx <= next_rx;
      is_read <= next_is_read;
      link.sclk <= next_sclk;
      link.cs_n <= next_cs_n;
      link.sdio_host_out <= next_out;
      link.sdio_host_oe <= next_oe;
      req_ready <= next_ready;
      resp_valid <= next_resp_valid;
      resp_data <= next_resp_data;
    end
  end

endmodule : ctrl_port_host

// ===== core/ctrl_port_pkg.sv
// Purpose: Shared constants and types for the serial control port.
// Assumes: Reference clock of 4 ns, link clock of 32 ns made by the host.
// Notes:   Frame is direction bit, 15 address bits, one data byte, MSB first.
package ctrl_port_pkg;

  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int FRAME_BITS = 24;
  localparam int HEAD_BITS = 16;
  localparam int ADDR_BITS = 15;
  localparam int DATA_BITS = 8;
  localparam logic [4:0] FRAME_LAST = 5'(FRAME_BITS - 1);
  localparam logic [4:0] HEAD_LAST = 5'(HEAD_BITS - 1);
  localparam logic [4:0] HEAD_COUNT = 5'(HEAD_BITS);
  localparam logic [4:0] FRAME_COUNT = 5'(FRAME_BITS);
  localparam logic DIR_READ = 1'b1;

  // ---------------------------------------------------------------
  // Device register file
  // ---------------------------------------------------------------
  localparam int REG_COUNT = 16;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int REF_PERIOD_NS = 4;
  localparam int LINK_PERIOD_NS = 32;
  localparam logic [2:0] DIV_HALF = 3'(LINK_PERIOD_NS / (2 * REF_PERIOD_NS));
  localparam logic [2:0] DIV_LAST = 3'(LINK_PERIOD_NS / REF_PERIOD_NS - 1);
  localparam logic [2:0] DIV_CS_RISE = 3'(LINK_PERIOD_NS / (2 * REF_PERIOD_NS) - 1);

  // ---------------------------------------------------------------
  // Host sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [3:0]
  {
    H_IDLE = 4'b0001,
    H_LEAD = 4'b0010,
    H_BITS = 4'b0100,
    H_TAIL = 4'b1000
  } host_state_t;

endpackage : ctrl_port_pkg

// ===== test/ctrl_port_monitor.sv
// Purpose: Watches the serial control link between host and device.
// Assumes: The link clock is made from ref_clk, so ref_clk samples the wire cleanly.
// Notes:   A helper counter tracks link clock rises and the direction bit of a frame.
module ctrl_port_monitor
  import ctrl_port_pkg::*;
(
  // Reference clock domain
  input wire logic ref_clk,
  input wire logic rst,
  // Configuration
  input wire logic three_wire,
  // Link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_host_oe,
  input wire logic sdio_dev_oe,
  input wire logic serial_data_output_oe,
  input wire logic sdio
);
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------
  // Helper logic
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  logic sclk_q;
  logic [4:0] cnt;
  logic dir_q;
  logic oe_any;

  // Either device lane being driven.
  assign oe_any = sdio_dev_oe | serial_data_output_oe;

  // Counts link clock rises in a frame and keeps the first bit.
  always_ff @(posedge ref_clk)
  begin
    sclk_q <= sclk;
    if (rst || cs_n)
    begin
      cnt <= 5'h0;
      dir_q <= 1'b0;
    end
    else if (sclk && !sclk_q)
    begin
      cnt <= cnt + 5'h1;
      if (cnt == 5'h0)
        dir_q <= sdio;
    end
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  property p_idle_sclk;
    cs_n |-> !sclk;
  endproperty
  a_idle_sclk: assert property (p_idle_sclk)
    else $error("link clock runs outside a frame");

  property p_sclk_high;
    $rose(sclk) |-> sclk [*4] ##1 !sclk;
  endproperty
  a_sclk_high: assert property (p_sclk_high)
    else $error("link clock high phase has the wrong length");

  property p_frame_len;
    $rose(cs_n) |-> (cnt == FRAME_COUNT);
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame does not hold 24 bit periods");

  property p_host_head;
    (sclk && cnt < HEAD_COUNT) |-> sdio_host_oe;
  endproperty
  a_host_head: assert property (p_host_head)
    else $error("host not driving the frame head");

  property p_oe_start;
    $rose(oe_any) |-> (cnt == HEAD_COUNT) && !sclk;
  endproperty
  a_oe_start: assert property (p_oe_start)
    else $error("device answer starts at the wrong bit");

  property p_oe_drop;
    $fell(oe_any) |-> (cnt == FRAME_COUNT);
  endproperty
  a_oe_drop: assert property (p_oe_drop)
    else $error("device answer ends at the wrong bit");

  property p_write_quiet;
    (!dir_q && cnt != 5'h0) |-> !oe_any;
  endproperty
  a_write_quiet: assert property (p_write_quiet)
    else $error("device drives during a write frame");

  // Bit 20 lies inside the answer byte of a read.
  property p_read_answers;
    (dir_q && cnt == 5'h14) |-> oe_any && !sdio_host_oe;
  endproperty
  a_read_answers: assert property (p_read_answers)
    else $error("read answer not driven by the device alone");

  property p_lane_select;
    oe_any |-> (sdio_dev_oe == three_wire) && (serial_data_output_oe != three_wire);
  endproperty
  a_lane_select: assert property (p_lane_select)
    else $error("device answers on the wrong lane");

  property p_bit_stable;
    (sclk && sclk_q) |-> $stable(sdio);
  endproperty
  a_bit_stable: assert property (p_bit_stable)
    else $error("shared data changes while the link clock is high");

  // Main scenarios reached.
  c_read_3w: cover property ($rose(sdio_dev_oe));
  c_read_4w: cover property ($rose(serial_data_output_oe));
  c_write_end: cover property ($rose(cs_n) && !dir_q);

endmodule : ctrl_port_monitor

// ===== test/test_serial_control_port.sv
// Purpose: Joins host and device ends and checks register traffic over the link.
// Assumes: Both ends share one wiring choice, changed only between frames.
// Notes:   The bench records each frame from the wire to check its layout.
module test_serial_control_port import ctrl_port_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic ref_clk;
  logic rst;
  logic three_wire;
  logic req_valid;
  logic req_read;
  logic [ADDR_BITS-1:0] req_addr;
  logic [DATA_BITS-1:0] req_data;
  logic req_ready;
  logic resp_valid;
  logic [DATA_BITS-1:0] resp_data;
  logic cfg_wr_pulse;
  logic [ADDR_BITS-1:0] cfg_wr_addr;
  logic [DATA_BITS-1:0] cfg_wr_data;
  logic [FRAME_BITS-1:0] cap;
  int cap_n;
  int cycles;
  int num_errors;
  int num_checks;

  ctrl_link_if link ();

  ctrl_port_host ctrl_port_host_i (.ref_clk(ref_clk), .rst(rst), .three_wire(three_wire),
    .req_valid(req_valid), .req_read(req_read), .req_addr(req_addr), .req_data(req_data),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp_data(resp_data), .link(link));

  ctrl_port_device ctrl_port_device_i (.ref_clk(ref_clk), .rst(rst), .three_wire(three_wire),
    .cfg_wr_pulse(cfg_wr_pulse), .cfg_wr_addr(cfg_wr_addr), .cfg_wr_data(cfg_wr_data),
    .link(link));

  ctrl_port_monitor ctrl_port_monitor_i (.ref_clk(ref_clk), .rst(rst),
    .three_wire(three_wire), .sclk(link.sclk), .cs_n(link.cs_n),
    .sdio_host_oe(link.sdio_host_oe), .sdio_dev_oe(link.sdio_dev_oe),
    .serial_data_output_oe(link.serial_data_output_oe), .sdio(link.sdio));

  // Reference clock of 4 ns.
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Records each frame: host bits from the shared line, answers from the chosen lane.
  always @(posedge link.sclk)
  begin
    if (!link.cs_n)
    begin
      cap = {cap[FRAME_BITS-2:0],
        (!link.sdio_host_oe && !three_wire) ? link.serial_data_output_line : link.sdio};
      cap_n = cap_n + 1;
    end
  end

  always @(negedge link.cs_n) cap_n = 0;

  // A hang is cut short well past the expected run of about 4000 cycles.
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      stop_test();
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    if (num_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task automatic reset_dut();
    rst = 1'b1;
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
  endtask : reset_dut

  // One access; request address and data are scrambled once taken to catch a missing latch.
  task automatic access(input logic rd, input logic [ADDR_BITS-1:0] addr,
    input logic [DATA_BITS-1:0] wdata, input logic [DATA_BITS-1:0] exp);
    int i;
    for (i = 0; i < 300 && req_ready !== 1'b1; i++)
      @(negedge ref_clk);
    req_valid = 1'b1;
    req_read = rd;
    req_addr = addr;
    req_data = wdata;
    @(negedge ref_clk);
    req_valid = 1'b0;
    req_addr = ~addr;
    req_data = ~wdata;
    check(req_ready, 1'b0);
    if (rd)
    begin
      for (i = 0; i < 300 && resp_valid !== 1'b1; i++)
        @(negedge ref_clk);
      check(resp_valid, 1'b1);
      check(resp_data, exp);
    end
    else
    begin
      for (i = 0; i < 300 && cfg_wr_pulse !== 1'b1; i++)
        @(negedge ref_clk);
      check(cfg_wr_pulse, 1'b1);
      check(cfg_wr_addr, addr);
      check(cfg_wr_data, wdata);
    end
    check(cap, {rd, addr, rd ? exp : wdata});
    check(cap_n, FRAME_BITS);
    @(negedge ref_clk);
  endtask : access

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Registers read their reset value before any write.
  task automatic test_reset_values();
    access(1'b1, 15'h0000, 8'h00, REG_RESET);
    access(1'b1, 15'h000F, 8'h00, REG_RESET);
  endtask : test_reset_values

  // Writes cross first so the wiring choice settles before any read.
  task automatic test_mode(input logic tw);
    logic [DATA_BITS-1:0] flip;
    flip = {DATA_BITS{tw}};
    three_wire = tw;
    access(1'b0, 15'h0000, 8'hA5 ^ flip, 8'h00);
    access(1'b0, 15'h000F, 8'h81 ^ flip, 8'h00);
    access(1'b1, 15'h000F, 8'h00, 8'h81 ^ flip);
    access(1'b1, 15'h0000, 8'h00, 8'hA5 ^ flip);
    access(1'b0, 15'h0010, 8'hFF, 8'h00);
    access(1'b0, 15'h7FFF, 8'h3C, 8'h00);
    access(1'b1, 15'h0010, 8'h00, 8'h00);
    access(1'b1, 15'h000F, 8'h00, 8'h81 ^ flip);
    access(1'b1, 15'h0000, 8'h00, 8'hA5 ^ flip);
  endtask : test_mode

  // A reset between frames clears a written register.
  task automatic test_second_reset();
    reset_dut();
    access(1'b1, 15'h000F, 8'h00, REG_RESET);
  endtask : test_second_reset

  // Main sequence.
  initial
  begin
    rst = 1'b1;
    three_wire = 1'b0;
    req_valid = 1'b0;
    req_read = 1'b0;
    req_addr = 15'h0000;
    req_data = 8'h00;
    cap = 24'h00_0000;
    cap_n = 0;
    cycles = 0;
    num_errors = 0;
    num_checks = 0;
    reset_dut();
    test_reset_values();
    test_mode(1'b0);
    test_mode(1'b1);
    test_second_reset();
    stop_test();
  end

endmodule : test_serial_control_port
